// >>> rtl/sbcsp_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Update serial output on clock rising edge
// - Sample serial input on clock falling edge
// - Serial output released while select high
// - Host holds select low whole frame
// - Select rising edge latches received byte
// - Frames are exactly eight bits
// - Select rising edge wakes from Stop
// - Receive output mirrors bus level
// - Transmit low drives bus dominant
// - Transmit only in Normal mode
// - Flag transmit stuck dominant after 1 s
// - Bus wake needs deglitched dominant
// - Stop bus wake raises interrupt quickly
// - Pwm input drives enabled switches
// - Host enables pwm via control writes
// - Host keeps pwm below 10 kHz
// - Reset pin two-way, active low
// - Reset pin release enters Normal Request
// - Interrupt signals events and Stop wake
// - Status read releases interrupt
// - Reset pulse 1 ms then Normal Request
// - Normal Request times out after 150 ms
module sbcsp_dev #(
	parameter int RST_CYC = sbcsp_pkg::RST_PULSE_CYC,
	parameter int NRTO_CYC = sbcsp_pkg::NREQ_TMO_CYC,
	parameter int TXDOM_CYC = sbcsp_pkg::TXDOM_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	sbcsp_if.dev lnk,
	input wire logic lin_bus_i,
	output logic lin_dom_o,
	output logic [1:0] high_side_switch_o,
	output logic [1:0] low_side_switch_o
);
	sbcsp_pkg::sbcsp_mode_t mode_r;
	logic [7:0] rx_r;
	logic [3:0] bitcnt_r;
	logic [2:0] txidx_r;
	logic miso_r;
	logic clr_n_r;
	logic [7:0] snap_r;
	logic cs_s, txd_s, pwm_s, rstpin_s, bus_s;
	logic sel_s, txd_dom_s, bus_dom_s;
	logic cs_q;
	logic cs_rise;
	logic frame_ok;
	logic [22:0] tmr_r;
	logic [11:0] wk_r;
	logic wake_hit;
	logic [25:0] txdom_r;
	logic txdom_flt;
	logic [3:0] flags_r;
	logic [3:0] flags_set;
	logic [2:0] high_side_ctrl_reg;
	logic [2:0] low_side_ctrl_reg;
	logic sw_act;
	logic rxd_r;
	logic irq_n_r;
	function automatic logic is_cmd(input logic [7:0] f, input logic [2:0] a);
		is_cmd = (f[sbcsp_pkg::ADDR_MSB:sbcsp_pkg::ADDR_LSB] == a);
	endfunction : is_cmd
	function automatic logic sw_drive(input logic [2:0] c, input logic i, input logic p);
		sw_drive = c[i] & (c[sbcsp_pkg::SW_PWM_BIT] ? p : 1'b1);
	endfunction : sw_drive
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	sbcsp_sync #(.W(5)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i({~lnk.cs_n, ~lnk.txd_lvl, lnk.pwm, lnk.rst_lvl, ~lin_bus_i}),
		.q_o({sel_s, txd_dom_s, pwm_s, rstpin_s, bus_dom_s})
	);
	// Select, transmit and bus pins kept inverted so a cleared synchroniser reads idle,
	// otherwise a false select rise follows every reset
	assign cs_s = ~sel_s;
	assign txd_s = ~txd_dom_s;
	assign bus_s = ~bus_dom_s;
	// ----------------------------------------
	// Serial clock domain
	// ----------------------------------------
	// Counters are cleared by a flop from clk_i while select is high,
	// so they hold still until clk_i has taken the frame over.
	// falling edge capture
	always_ff @(negedge lnk.sclk or negedge clr_n_r)
	begin
		if (!clr_n_r)
		begin
			rx_r <= 8'h00;
			bitcnt_r <= 4'h0;
		end
		else
		begin
			rx_r <= {rx_r[6:0], lnk.mosi};
			if (bitcnt_r != 4'hf)
				bitcnt_r <= bitcnt_r + 4'h1;
		end
	end
	always_ff @(posedge lnk.sclk or negedge clr_n_r)
	begin
		if (!clr_n_r)
		begin
			miso_r <= 1'b0;
			txidx_r <= 3'h0;
		end
		else
		begin
			miso_r <= snap_r[3'h7 - txidx_r];
			txidx_r <= txidx_r + 3'h1;
		end
	end
	assign lnk.miso = miso_r;
	assign lnk.miso_oe = ~lnk.cs_n;
	// ----------------------------------------
	// Frame takeover
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cs_q <= 1'b1;
		else
			cs_q <= cs_s;
	end
	// end of frame on select rise
	assign cs_rise = cs_s & ~cs_q;
	assign frame_ok = cs_rise && (bitcnt_r == sbcsp_pkg::FRAME_BITS_CNT);
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			clr_n_r <= 1'b0;
		else if (cs_s & cs_q)
			clr_n_r <= 1'b0;
		else if (!cs_s)
			clr_n_r <= 1'b1;
	end
	// Status frozen while the frame is clocked out
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			snap_r <= 8'h00;
		else if (cs_s)
			snap_r <= {1'b0, mode_r, flags_r};
	end
	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	assign wake_hit = (mode_r == sbcsp_pkg::M_STOP) ? (wk_r == sbcsp_pkg::WAKE_STOP_CYC)
		: (wk_r == sbcsp_pkg::WAKE_FILT_CYC);
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mode_r <= sbcsp_pkg::M_RST;
			tmr_r <= 23'h0;
		end
		else
		begin
			tmr_r <= tmr_r + 23'h1;
			case (mode_r)
				sbcsp_pkg::M_RST:
					if (tmr_r == 23'(RST_CYC - 1))
						mode_r <= sbcsp_pkg::M_EXT;
				sbcsp_pkg::M_EXT:
				begin
					tmr_r <= 23'h0;
					if (rstpin_s)
						mode_r <= sbcsp_pkg::M_NREQ;
				end
				sbcsp_pkg::M_NREQ:
					if (!rstpin_s)
						mode_r <= sbcsp_pkg::M_EXT;
					else if (frame_ok && is_cmd(rx_r, sbcsp_pkg::ADDR_MODE) && rx_r[1:0] == sbcsp_pkg::MODE_CMD_NORMAL)
						mode_r <= sbcsp_pkg::M_NORM;
					else if (tmr_r == 23'(NRTO_CYC - 1))
					begin
						mode_r <= sbcsp_pkg::M_RST;
						tmr_r <= 23'h0;
					end
				sbcsp_pkg::M_NORM:
				begin
					tmr_r <= 23'h0;
					if (!rstpin_s)
						mode_r <= sbcsp_pkg::M_EXT;
					else if (frame_ok && is_cmd(rx_r, sbcsp_pkg::ADDR_MODE))
					begin
						if (rx_r[1:0] == sbcsp_pkg::MODE_CMD_STOP)
							mode_r <= sbcsp_pkg::M_STOP;
						else if (rx_r[1:0] == sbcsp_pkg::MODE_CMD_SLEEP)
							mode_r <= sbcsp_pkg::M_SLEEP;
					end
				end
				sbcsp_pkg::M_STOP:
				begin
					tmr_r <= 23'h0;
					if (!rstpin_s)
						mode_r <= sbcsp_pkg::M_EXT;
					else if (cs_rise || wake_hit)
						mode_r <= sbcsp_pkg::M_NREQ;
				end
				sbcsp_pkg::M_SLEEP:
				begin
					tmr_r <= 23'h0;
					if (wake_hit)
						mode_r <= sbcsp_pkg::M_RST;
				end
				default:
					mode_r <= sbcsp_pkg::M_RST;
			endcase
		end
	end
	assign lnk.rst_dev_oe = (mode_r == sbcsp_pkg::M_RST);
	// ----------------------------------------
	// Bus wake filter and stuck transmit
	// ----------------------------------------
	// dominant must persist
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wk_r <= 12'h0;
		else if (bus_s || !(mode_r == sbcsp_pkg::M_STOP || mode_r == sbcsp_pkg::M_SLEEP))
			wk_r <= 12'h0;
		else if (!wake_hit)
			wk_r <= wk_r + 12'h1;
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			txdom_r <= 26'h0;
		else if (txd_s)
			txdom_r <= 26'h0;
		else if (!txdom_flt)
			txdom_r <= txdom_r + 26'h1;
	end
	assign txdom_flt = (txdom_r == 26'(TXDOM_CYC));
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lin_dom_o <= 1'b0;
		else
			lin_dom_o <= (mode_r == sbcsp_pkg::M_NORM) & ~txd_s & ~txdom_flt;
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rxd_r <= 1'b1;
		else
			rxd_r <= bus_s;
	end
	assign lnk.rxd = rxd_r;
	// ----------------------------------------
	// Status flags and interrupt
	// ----------------------------------------
	always_comb
	begin
		flags_set = 4'h0;
		flags_set[sbcsp_pkg::FL_LINWAKE] = wake_hit & (mode_r == sbcsp_pkg::M_STOP || mode_r == sbcsp_pkg::M_SLEEP);
		flags_set[sbcsp_pkg::FL_CSWAKE] = cs_rise & (mode_r == sbcsp_pkg::M_STOP);
		flags_set[sbcsp_pkg::FL_TXDOM] = ~txd_s & (txdom_r == 26'(TXDOM_CYC - 1));
		flags_set[sbcsp_pkg::FL_EXTRST] = ~rstpin_s & (mode_r != sbcsp_pkg::M_RST) & (mode_r != sbcsp_pkg::M_EXT);
	end
	// read acknowledges reported bits, new events win
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			flags_r <= sbcsp_pkg::FLAGS_RST;
		else if (frame_ok && is_cmd(rx_r, sbcsp_pkg::ADDR_STAT))
			flags_r <= (flags_r & ~snap_r[3:0]) | flags_set;
		else
			flags_r <= flags_r | flags_set;
	end
	// interrupt in active modes and on Stop wake
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			irq_n_r <= 1'b1;
		else
			irq_n_r <= ~((|flags_r) & (mode_r == sbcsp_pkg::M_NREQ || mode_r == sbcsp_pkg::M_NORM
				|| mode_r == sbcsp_pkg::M_STOP));
	end
	assign lnk.irq_n = irq_n_r;
	// ----------------------------------------
	// Switch control
	// ----------------------------------------
	// control written by host frames
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			high_side_ctrl_reg <= sbcsp_pkg::SW_CTL_RST;
			low_side_ctrl_reg <= sbcsp_pkg::SW_CTL_RST;
		end
		else if (mode_r == sbcsp_pkg::M_RST)
		begin
			high_side_ctrl_reg <= sbcsp_pkg::SW_CTL_RST;
			low_side_ctrl_reg <= sbcsp_pkg::SW_CTL_RST;
		end
		else if (frame_ok && is_cmd(rx_r, sbcsp_pkg::ADDR_HSCTL))
			high_side_ctrl_reg <= rx_r[2:0];
		else if (frame_ok && is_cmd(rx_r, sbcsp_pkg::ADDR_LSCTL))
			low_side_ctrl_reg <= rx_r[2:0];
	end
	assign sw_act = (mode_r == sbcsp_pkg::M_NREQ) || (mode_r == sbcsp_pkg::M_NORM);
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_sw
			always_ff @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					high_side_switch_o[g] <= 1'b0;
					low_side_switch_o[g] <= 1'b0;
				end
				else
				begin
					high_side_switch_o[g] <= sw_act & sw_drive(high_side_ctrl_reg, 1'(g), pwm_s);
					low_side_switch_o[g] <= sw_act & sw_drive(low_side_ctrl_reg, 1'(g), pwm_s);
				end
			end
		end
	endgenerate
endmodule : sbcsp_dev
`default_nettype wire

// >>> rtl/sbcsp_pkg.sv
`default_nettype none
package sbcsp_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int RST_PULSE_US = 1000;
	localparam int NREQ_TMO_MS = 150;
	localparam int TXDOM_MS = 1000;
	localparam int WAKE_FILT_US = 70;
	localparam int WAKE_STOP_US = 27;
	localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_PER_US;
	localparam int NREQ_TMO_CYC = NREQ_TMO_MS * 1000 * CLK_PER_US;
	localparam int TXDOM_CYC = TXDOM_MS * 1000 * CLK_PER_US;
	localparam logic [11:0] WAKE_FILT_CYC = 12'(WAKE_FILT_US * CLK_PER_US);
	localparam logic [11:0] WAKE_STOP_CYC = 12'(WAKE_STOP_US * CLK_PER_US);
	// Host serial clock half period, 50 MHz / 16 = 3.125 MHz
	localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 8;
	localparam logic [3:0] FRAME_BITS_CNT = 4'h8;
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 5;
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_HSCTL = 3'h1;
	localparam logic [2:0] ADDR_LSCTL = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
	localparam logic [1:0] MODE_CMD_STOP = 2'h1;
	localparam logic [1:0] MODE_CMD_SLEEP = 2'h2;
	// Switch control field: bits 1:0 enable, bit 2 follows pwm input
	localparam int SW_PWM_BIT = 2;
	localparam logic [2:0] SW_CTL_RST = 3'h0;
	// Status flag positions
	localparam int FL_LINWAKE = 0;
	localparam int FL_CSWAKE = 1;
	localparam int FL_TXDOM = 2;
	localparam int FL_EXTRST = 3;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	typedef enum logic [2:0] {
		M_RST, M_EXT, M_NREQ, M_NORM, M_STOP, M_SLEEP
	} sbcsp_mode_t;
endpackage : sbcsp_pkg
`default_nettype wire

// >>> rtl/sbcsp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sbcsp_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic txd;
	logic txd_oe;
	logic rxd;
	logic irq_n;
	logic pwm;
	logic rst_dev_oe;
	logic rst_host_oe;
	logic miso_lvl;
	logic txd_lvl;
	logic rst_lvl;
	// ----------------------------------------
	// Wire levels with pull-ups
	// ----------------------------------------
	assign miso_lvl = miso_oe ? miso : 1'b1;
	assign txd_lvl = txd_oe ? txd : 1'b1;
	assign rst_lvl = ~(rst_dev_oe | rst_host_oe);
	modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe, input txd_lvl,
		output rxd, output irq_n, input pwm, output rst_dev_oe, input rst_lvl);
	modport host (output sclk, output cs_n, output mosi, input miso_lvl, output txd, output txd_oe,
		input rxd, input irq_n, output pwm, output rst_host_oe, input rst_lvl);
endinterface : sbcsp_if
`default_nettype wire

// >>> rtl/sbcsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sbcsp_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_r <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : sbcsp_sync
`default_nettype wire

// >>> rtl/sbcsp_host.sv
`timescale 1ns/10ps
`default_nettype none
module sbcsp_host (
	input wire logic clk_i,
	input wire logic rstn_i,
	sbcsp_if.host lnk,
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	input wire logic lin_tx_i,
	input wire logic lin_tx_en_i,
	output logic lin_rx_o,
	output logic irq_o,
	input wire logic pwm_control_in_i,
	input wire logic mcu_rst_req_i,
	output logic mcu_in_reset_o
);
	typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_GAP} sbcsp_hst_t;
	sbcsp_hst_t st_r;
	logic [3:0] dv_r;
	logic [3:0] nb_r;
	logic [7:0] sh_r;
	logic [7:0] rv_r;
	logic sclk_r, cs_n_r, mosi_r, txd_r, pwm_r;
	logic miso_s, rxd_dom_s, irq_s, rst_s;
	logic half;
	sbcsp_sync #(.W(4)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i({lnk.miso_lvl, ~lnk.rxd, ~lnk.irq_n, lnk.rst_lvl}),
		.q_o({miso_s, rxd_dom_s, irq_s, rst_s})
	);
	assign half = (dv_r == sbcsp_pkg::SCLK_HALF_CYC - 4'h1);
	assign cmd_ready_o = (st_r == H_IDLE);
	// ----------------------------------------
	// Frame engine, serial clock by divider
	// ----------------------------------------
	// select held over eight bits
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_r <= H_IDLE;
			dv_r <= 4'h0;
			nb_r <= 4'h0;
			sh_r <= 8'h00;
			rv_r <= 8'h00;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			mosi_r <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 8'h00;
		end
		else
		begin
			rsp_valid_o <= 1'b0;
			dv_r <= half ? 4'h0 : dv_r + 4'h1;
			case (st_r)
				H_IDLE:
				begin
					dv_r <= 4'h0;
					if (cmd_valid_i)
					begin
						sh_r <= cmd_data_i;
						cs_n_r <= 1'b0;
						nb_r <= 4'h0;
						st_r <= H_LEAD;
					end
				end
				H_LEAD:
					if (half)
						st_r <= H_SHIFT;
				H_SHIFT:
					if (half)
					begin
						sclk_r <= ~sclk_r;
						if (!sclk_r)
							mosi_r <= sh_r[7];
						else
						begin
							sh_r <= {sh_r[6:0], 1'b0};
							rv_r <= {rv_r[6:0], miso_s};
							nb_r <= nb_r + 4'h1;
							if (nb_r == sbcsp_pkg::FRAME_BITS_CNT - 4'h1)
								st_r <= H_GAP;
						end
					end
				H_GAP:
				begin
					if (!cs_n_r)
					begin
						rsp_valid_o <= 1'b1;
						rsp_data_o <= rv_r;
					end
					cs_n_r <= 1'b1;
					if (half && nb_r == sbcsp_pkg::FRAME_BITS_CNT)
						nb_r <= 4'h0;
					else if (half)
						st_r <= H_IDLE;
				end
				default:
					st_r <= H_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			txd_r <= 1'b1;
			pwm_r <= 1'b0;
		end
		else
		begin
			txd_r <= lin_tx_i;
			pwm_r <= pwm_control_in_i;
		end
	end
	assign lnk.sclk = sclk_r;
	assign lnk.cs_n = cs_n_r;
	assign lnk.mosi = mosi_r;
	assign lnk.txd = txd_r;
	assign lnk.txd_oe = lin_tx_en_i;
	assign lnk.pwm = pwm_r;
	assign lnk.rst_host_oe = mcu_rst_req_i;
	// Receive and interrupt pins kept inverted so their outputs read idle out of reset
	assign lin_rx_o = ~rxd_dom_s;
	assign irq_o = irq_s;
	assign mcu_in_reset_o = ~rst_s;
endmodule : sbcsp_host
`default_nettype wire

// >>> bench/sbcsp_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sbcsp_properties #(
	parameter int RST_CYC = 50,
	parameter int TXDOM_CYC = 300
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic txd_lvl,
	input wire logic rxd,
	input wire logic irq_n,
	input wire logic rst_dev_oe,
	input wire logic lin_bus_i,
	input wire logic lin_dom_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [3:0] rise_r;
	logic [7:0] shf_r;
	logic [3:0] ack_age_r;
	int oe_run_r;
	int dom_run_r;
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			rise_r <= 4'h0;
		else if (cs_n)
			rise_r <= 4'h0;
		else if ($rose(sclk))
			rise_r <= rise_r + 4'h1;
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			shf_r <= 8'h00;
		else if ($fell(sclk))
			shf_r <= {shf_r[6:0], mosi};
	// Saturates so a stale read never excuses a late release
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			ack_age_r <= 4'hf;
		else if ($rose(cs_n) && shf_r[7:5] == 3'h3)
			ack_age_r <= 4'h0;
		else if (ack_age_r != 4'hf)
			ack_age_r <= ack_age_r + 4'h1;
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			oe_run_r <= 0;
		else
			oe_run_r <= rst_dev_oe ? oe_run_r + 1 : 0;
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
			dom_run_r <= 0;
		else
			dom_run_r <= lin_dom_o ? dom_run_r + 1 : 0;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	miso_launch_a: assert property (!cs_n && $changed(miso) |-> $rose(sclk))
		else $error("serial output moved off clock rise");
	mosi_hold_a: assert property ($fell(sclk) |-> $stable(mosi))
		else $error("serial input moved at clock fall");
	miso_hiz_a: assert property (miso_oe == !cs_n)
		else $error("serial output enable wrong for select");
	sel_hold_a: assert property (sclk |-> !cs_n)
		else $error("serial clock high outside frame");
	frame_bits_a: assert property ($rose(cs_n) |-> rise_r == 4'h8)
		else $error("frame without eight clocks");
	rx_dom_a: assert property ((!lin_bus_i) [*5] |-> !rxd)
		else $error("receive high on dominant bus");
	rx_rec_a: assert property (lin_bus_i [*5] |-> rxd)
		else $error("receive low on recessive bus");
	tx_idle_a: assert property (txd_lvl [*5] |-> !lin_dom_o)
		else $error("bus driven with transmit recessive");
	txd_stuck_a: assert property (dom_run_r <= TXDOM_CYC + 1)
		else $error("bus held dominant past stuck limit");
	irq_release_a: assert property ($rose(irq_n) |-> ack_age_r < 4'hc)
		else $error("interrupt released without status read");
	rst_pulse_a: assert property ($fell(rst_dev_oe) |-> oe_run_r >= RST_CYC - 1 && oe_run_r <= RST_CYC + 2)
		else $error("reset pulse length wrong");
	cover property ($rose(cs_n));
	cover property ($fell(irq_n));
	cover property ($fell(rst_dev_oe));
endmodule : sbcsp_properties
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int RST_CYC = 50;
	localparam int NRTO_CYC = 2000;
	localparam int TXDOM_CYC = 300;
	logic clk_i, rstn_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, lin_tx_i, lin_tx_en_i, lin_rx_o, irq_o;
	logic pwm_control_in_i, mcu_rst_req_i, mcu_in_reset_o, lin_bus_i, lin_dom_o, bus_pull;
	logic [7:0] cmd_data_i;
	logic [7:0] rsp_data_o;
	logic [1:0] high_side_switch_o;
	logic [1:0] low_side_switch_o;
	int miscompares, tests_run, seed, mode, flags, cnt;
	sbcsp_if lnk();
	// Open-collector bus with pull-up
	assign lin_bus_i = ~(lin_dom_o | bus_pull);
	sbcsp_dev #(.RST_CYC(RST_CYC), .NRTO_CYC(NRTO_CYC), .TXDOM_CYC(TXDOM_CYC)) u_sbcsp_dev (.clk_i(clk_i),
		.rstn_i(rstn_i), .lnk(lnk), .lin_bus_i(lin_bus_i), .lin_dom_o(lin_dom_o),
		.high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o));
	sbcsp_host u_sbcsp_host (.clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk), .cmd_valid_i(cmd_valid_i),
		.cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.lin_tx_i(lin_tx_i), .lin_tx_en_i(lin_tx_en_i), .lin_rx_o(lin_rx_o), .irq_o(irq_o),
		.pwm_control_in_i(pwm_control_in_i), .mcu_rst_req_i(mcu_rst_req_i), .mcu_in_reset_o(mcu_in_reset_o));
	sbcsp_properties #(.RST_CYC(RST_CYC), .TXDOM_CYC(TXDOM_CYC)) u_sbcsp_properties (.clk_i(clk_i),
		.rstn_i(rstn_i), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
		.miso_oe(lnk.miso_oe), .txd_lvl(lnk.txd_lvl), .rxd(lnk.rxd), .irq_n(lnk.irq_n),
		.rst_dev_oe(lnk.rst_dev_oe), .lin_bus_i(lin_bus_i), .lin_dom_o(lin_dom_o));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Checking and model
	// ----------------------------------------
	task automatic test_done();
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	// Snapshot is what the frame returns; ack clears only those flags
	task automatic frame(input logic [7:0] cmd);
		int snap;
		int snapm;
		int n;
		snap = flags;
		snapm = mode;
		n = 0;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_data_i = cmd;
		while (cmd_ready_o !== 1'b1 && n < 400)
		begin
			n++;
			@(negedge clk_i);
		end
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1 && n < 800)
		begin
			n++;
			@(negedge clk_i);
		end
		if (n >= 800)
		begin
			miscompares++;
			$display("Error %0t response timed out", $time);
		end
		cmp8(rsp_data_o, {1'b0, 3'(snapm), 4'(snap)});
		if (cmd[7:5] == 3'h3)
			flags = flags & ~snap;
		if (mode == 4)
		begin
			mode = 2;
			flags = flags | 2;
		end
		else if (cmd == 8'h00 && (mode == 2 || mode == 3))
			mode = 3;
		else if (cmd == 8'h01 && mode == 3)
			mode = 4;
		else if (cmd == 8'h02 && mode == 3)
			mode = 5;
		tick(20);
		cmp8({7'h0, irq_o}, {7'h0, flags != 0 && mode != 4});
	endtask : frame
	initial
	begin
		#1_000_000;
		miscompares++;
		test_done();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		seed = 32'h5ddb;
		{miscompares, tests_run, mode, flags} = '0;
		{rstn_i, cmd_valid_i, cmd_data_i, lin_tx_en_i, pwm_control_in_i, mcu_rst_req_i, bus_pull} = '0;
		lin_tx_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rstn_i = 1'b1;
		tick(RST_CYC + 30);
		mode = 2;
		cmp8({7'h0, mcu_in_reset_o}, 8'h00);
		frame(8'h60);
		frame(8'h00);
		frame(8'h23);
		frame(8'h47);
		repeat (4)
		begin
			pwm_control_in_i = 1'($random(seed));
			tick(2500);
			cmp8({6'h0, low_side_switch_o}, {6'h0, {2{pwm_control_in_i}}});
			cmp8({6'h0, high_side_switch_o}, 8'h03);
		end
		lin_tx_en_i = 1'b1;
		lin_tx_i = 1'b0;
		tick(20);
		cmp8({6'h0, lin_dom_o, lin_rx_o}, 8'h02);
		tick(TXDOM_CYC + 20);
		cmp8({7'h0, lin_dom_o}, 8'h00);
		flags = flags | 4;
		lin_tx_i = 1'b1;
		tick(10);
		frame(8'h60);
		repeat (8)
		begin
			lin_tx_i = 1'($random(seed));
			tick(20);
			cmp8({6'h0, lin_dom_o, lin_rx_o}, {6'h0, ~lin_tx_i, lin_tx_i});
		end
		lin_tx_i = 1'b1;
		frame(8'h01);
		frame(8'h60);
		lin_tx_i = 1'b0;
		tick(20);
		cmp8({7'h0, lin_dom_o}, 8'h00);
		lin_tx_i = 1'b1;
		frame(8'h60);
		frame(8'h00);
		frame(8'h01);
		// Bus wake timed from the dominant edge to the interrupt
		bus_pull = 1'b1;
		cnt = 0;
		while (irq_o !== 1'b1 && cnt < 3000)
		begin
			cnt++;
			tick(1);
		end
		cmp8({7'h0, cnt >= 450 && cnt <= 1760}, 8'h01);
		bus_pull = 1'b0;
		mode = 2;
		flags = flags | 1;
		tick(10);
		frame(8'h60);
		mcu_rst_req_i = 1'b1;
		tick(20);
		cmp8({7'h0, mcu_in_reset_o}, 8'h01);
		mcu_rst_req_i = 1'b0;
		tick(20);
		flags = flags | 8;
		frame(8'h60);
		cnt = 0;
		repeat (NRTO_CYC + RST_CYC + 60)
		begin
			tick(1);
			if (mcu_in_reset_o === 1'b1)
				cnt++;
		end
		cmp8({7'h0, cnt > 0}, 8'h01);
		frame(8'h60);
		// Sleep wake goes through the long filter and a reset pulse
		frame(8'h00);
		frame(8'h02);
		bus_pull = 1'b1;
		cnt = 0;
		while (mcu_in_reset_o !== 1'b1 && cnt < 6000)
		begin
			cnt++;
			tick(1);
		end
		cmp8({7'h0, cnt >= 2100 && cnt <= 4760}, 8'h01);
		bus_pull = 1'b0;
		mode = 2;
		flags = flags | 1;
		tick(RST_CYC + 30);
		frame(8'h60);
		test_done();
	end
endmodule : testbench
`default_nettype wire
